/* File: design/dbl_defs.svh */
// register map, field positions, reset values and timing figures of the drive bay led controller
// assumes a 32-bit apb slave with one register per aligned word
`ifndef DBL_DEFS_SVH
`define DBL_DEFS_SVH

`define DBL_SLOTS 8
`define DBL_ADDR_W 8
`define DBL_OFF_CTRL 8'h00
`define DBL_OFF_FAULT 8'h04
`define DBL_OFF_REBUILD 8'h08
`define DBL_OFF_IDENT 8'h0C
`define DBL_OFF_SPINDN 8'h10
`define DBL_OFF_STATE 8'h14
`define DBL_OFF_INT_STAT 8'h18
`define DBL_OFF_INT_MASK 8'h1C
`define DBL_CTRL_SAS_BIT 0
`define DBL_CTRL_PWR_BIT 1
`define DBL_INT_DONE_BIT 8
`define DBL_INT_W 9
`define DBL_CTRL_RST 2'h0
`define DBL_CLK_HZ 250000000
`define DBL_BLINK_RB_HZ 1
`define DBL_BLINK_ID_HZ 2
`define DBL_BLINK_ACT_HZ 4
`define DBL_SPINUP_MS 500
`define DBL_HALF_RB (`DBL_CLK_HZ / (2 * `DBL_BLINK_RB_HZ))
`define DBL_HALF_ID (`DBL_CLK_HZ / (2 * `DBL_BLINK_ID_HZ))
`define DBL_HALF_ACT (`DBL_CLK_HZ / (2 * `DBL_BLINK_ACT_HZ))
`define DBL_SPINUP_CYC ((`DBL_CLK_HZ / 1000) * `DBL_SPINUP_MS)

`endif

/* File: design/dbl_pkg.sv */
// types shared by the drive bay led controller
// assumes dbl_defs.svh for all numeric constants
`default_nettype none
package dbl_pkg;
	typedef enum logic [1:0] {
		DBL_PWR_OFF = 2'b00,
		DBL_PWR_SPIN = 2'b01,
		DBL_PWR_ON = 2'b11
	} dbl_pwr_t;
endpackage
`default_nettype wire

/* File: design/dbl_ctrl.sv */
// drive bay led controller: eight slots of amber status and green activity leds,
// drive present outputs and staggered drive power-up, managed over apb.
// assumes pclk at 250 MHz; drive detect and activity pins are asynchronous.
// What this block does
// - amber led dark when the slot has no fault, rebuild or identify request.
// - amber led lit steadily while a fault is reported for the slot.
// - amber blinks 1 Hz during rebuild, 2 Hz during identify.
// - idle powered drive: green lit for sas, dark for sata.
// - sas drive busy: green blinks off from its lit idle state.
// - sata drive busy: green blinks on from its dark idle state.
// - spun down drive keeps green dark for both drive types.
// - spinning up: green blinks for sas, stays dark for sata.
// - drive present driven per slot; drive power enabled one slot at a time.
// - management reaches the block over a bridged, chainable management bus.
// - eight slots, each with status led, activity led and present signal.
//
// The placing of the registers and register access over APB are this design's own decisions.
`timescale 1ns/1ps
`include "dbl_defs.svh"
`default_nettype none

module dbl_ctrl #(
	parameter int unsigned SLOTS = `DBL_SLOTS,
	parameter logic [31:0] HALF_RB = 32'(`DBL_HALF_RB),
	parameter logic [31:0] HALF_ID = 32'(`DBL_HALF_ID),
	parameter logic [31:0] HALF_ACT = 32'(`DBL_HALF_ACT),
	parameter logic [31:0] SPINUP_CYC = 32'(`DBL_SPINUP_CYC)
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`DBL_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic irq,
	input wire logic [SLOTS-1:0] drv_detect_n,
	input wire logic [SLOTS-1:0] drv_busy,
	output logic [SLOTS-1:0] led_amber,
	output logic [SLOTS-1:0] led_green,
	output logic [SLOTS-1:0] drv_present,
	output logic [SLOTS-1:0] drv_pwr_en
);
	localparam int IW = `DBL_INT_W;

	logic [1:0] ctrl_r, ctrl_nxt;
	logic [SLOTS-1:0] fault_r, fault_nxt, rebuild_r, rebuild_nxt, ident_r, ident_nxt, spindn_r, spindn_nxt;
	logic [IW-1:0] istat_r, istat_nxt, imask_r, imask_nxt;
	logic [31:0] prdata_r, prdata_nxt;
	logic pready_r, pready_nxt, pslverr_r, pslverr_nxt, irq_r, irq_nxt;
	logic [SLOTS-1:0] det_s1_r, det_s2_r, busy_s1_r, busy_s2_r, pres_r, pres_nxt;
	logic [31:0] cnt_rb_r, cnt_rb_nxt, cnt_id_r, cnt_id_nxt, cnt_act_r, cnt_act_nxt;
	logic blink_rb_r, blink_rb_nxt, blink_id_r, blink_id_nxt, blink_act_r, blink_act_nxt;
	dbl_pkg::dbl_pwr_t pst_r, pst_nxt;
	logic [2:0] slot_r, slot_nxt;
	logic [31:0] spin_cnt_r, spin_cnt_nxt;
	logic [SLOTS-1:0] pwr_r, pwr_nxt, amber_r, amber_nxt, green_r, green_nxt;
	logic setup, access, done_evt;

	function automatic logic known_addr(input logic [`DBL_ADDR_W-1:0] a);
		unique case (a)
			`DBL_OFF_CTRL, `DBL_OFF_FAULT, `DBL_OFF_REBUILD, `DBL_OFF_IDENT,
			`DBL_OFF_SPINDN, `DBL_OFF_STATE, `DBL_OFF_INT_STAT, `DBL_OFF_INT_MASK: known_addr = 1'b1;
			default: known_addr = 1'b0;
		endcase
	endfunction

	function automatic logic [SLOTS-1:0] fit(input logic [31:0] v);
		fit = v[SLOTS-1:0];
	endfunction

	// the management bus is bridged onto apb; chaining to the next backplane is outside this block
	assign setup = psel && !penable;
	assign access = psel && penable && pready_r;

	// two flops on every drive detect and busy pin before any logic reads it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			det_s1_r <= '1;
			det_s2_r <= '1;
			busy_s1_r <= '0;
			busy_s2_r <= '0;
		end else if (ce) begin
			det_s1_r <= drv_detect_n;
			det_s2_r <= det_s1_r;
			busy_s1_r <= drv_busy;
			busy_s2_r <= busy_s1_r;
		end
	end

	// blink dividers: toggle at each half period, so on and off times are equal
	always_comb begin
		cnt_rb_nxt = cnt_rb_r + 32'h1;
		blink_rb_nxt = blink_rb_r;
		if (cnt_rb_r == HALF_RB - 32'h1) begin
			cnt_rb_nxt = '0;
			blink_rb_nxt = !blink_rb_r;
		end
		cnt_id_nxt = cnt_id_r + 32'h1;
		blink_id_nxt = blink_id_r;
		if (cnt_id_r == HALF_ID - 32'h1) begin
			cnt_id_nxt = '0;
			blink_id_nxt = !blink_id_r;
		end
		cnt_act_nxt = cnt_act_r + 32'h1;
		blink_act_nxt = blink_act_r;
		if (cnt_act_r == HALF_ACT - 32'h1) begin
			cnt_act_nxt = '0;
			blink_act_nxt = !blink_act_r;
		end
	end

	// staggered power-up: one slot at a time, each given the spin-up time
	always_comb begin
		pst_nxt = pst_r;
		slot_nxt = slot_r;
		spin_cnt_nxt = spin_cnt_r;
		pwr_nxt = pwr_r;
		done_evt = 1'b0;
		unique case (pst_r)
			dbl_pkg::DBL_PWR_OFF: begin
				if (ctrl_r[`DBL_CTRL_PWR_BIT]) begin
					pst_nxt = dbl_pkg::DBL_PWR_SPIN;
					slot_nxt = '0;
					spin_cnt_nxt = '0;
					pwr_nxt = fit(32'h1);
				end
			end
			dbl_pkg::DBL_PWR_SPIN: begin
				spin_cnt_nxt = spin_cnt_r + 32'h1;
				if (spin_cnt_r == SPINUP_CYC - 32'h1) begin
					spin_cnt_nxt = '0;
					if (slot_r == 3'(SLOTS - 1)) begin
						pst_nxt = dbl_pkg::DBL_PWR_ON;
						done_evt = 1'b1;
					end else begin
						slot_nxt = slot_r + 3'h1;
						pwr_nxt[slot_r + 3'h1] = 1'b1;
					end
				end
			end
			dbl_pkg::DBL_PWR_ON: begin
			end
			default: pst_nxt = dbl_pkg::DBL_PWR_OFF;
		endcase
		if (!ctrl_r[`DBL_CTRL_PWR_BIT]) begin
			pst_nxt = dbl_pkg::DBL_PWR_OFF;
			pwr_nxt = '0;
		end
	end

	// led decode per slot
	always_comb begin
		for (int i = 0; i < SLOTS; i++) begin
			if (fault_r[i]) begin
				amber_nxt[i] = 1'b1;
			end else if (rebuild_r[i]) begin
				amber_nxt[i] = blink_rb_r;
			end else if (ident_r[i]) begin
				amber_nxt[i] = blink_id_r;
			end else begin
				amber_nxt[i] = 1'b0;
			end
			// the whole bay follows the single drive type bit
			if (!pwr_r[i] || spindn_r[i]) begin
				green_nxt[i] = 1'b0;
			end else if (pst_r == dbl_pkg::DBL_PWR_SPIN && slot_r == 3'(i)) begin
				green_nxt[i] = ctrl_r[`DBL_CTRL_SAS_BIT] && blink_act_r;
			end else if (busy_s2_r[i]) begin
				green_nxt[i] = ctrl_r[`DBL_CTRL_SAS_BIT] ? !blink_act_r : blink_act_r;
			end else begin
				green_nxt[i] = ctrl_r[`DBL_CTRL_SAS_BIT];
			end
		end
	end

	// register file, presence and interrupts
	always_comb begin
		ctrl_nxt = ctrl_r;
		fault_nxt = fault_r;
		rebuild_nxt = rebuild_r;
		ident_nxt = ident_r;
		spindn_nxt = spindn_r;
		imask_nxt = imask_r;
		istat_nxt = istat_r;
		prdata_nxt = prdata_r;
		pready_nxt = setup;
		pslverr_nxt = setup && !known_addr(paddr);
		pres_nxt = ~det_s2_r;
		if (setup) begin
			unique case (paddr)
				`DBL_OFF_CTRL: prdata_nxt = {30'h0, ctrl_r};
				`DBL_OFF_FAULT: prdata_nxt = 32'(fault_r);
				`DBL_OFF_REBUILD: prdata_nxt = 32'(rebuild_r);
				`DBL_OFF_IDENT: prdata_nxt = 32'(ident_r);
				`DBL_OFF_SPINDN: prdata_nxt = 32'(spindn_r);
				`DBL_OFF_STATE: prdata_nxt = {14'h0, pst_r, 8'(pwr_r), 8'(pres_r)};
				`DBL_OFF_INT_STAT: prdata_nxt = 32'(istat_r);
				`DBL_OFF_INT_MASK: prdata_nxt = 32'(imask_r);
				default: prdata_nxt = '0;
			endcase
		end
		if (access && pwrite) begin
			unique case (paddr)
				`DBL_OFF_CTRL: ctrl_nxt = pwdata[1:0];
				`DBL_OFF_FAULT: fault_nxt = fit(pwdata);
				`DBL_OFF_REBUILD: rebuild_nxt = fit(pwdata);
				`DBL_OFF_IDENT: ident_nxt = fit(pwdata);
				`DBL_OFF_SPINDN: spindn_nxt = fit(pwdata);
				`DBL_OFF_INT_STAT: istat_nxt = istat_r & ~pwdata[IW-1:0];
				`DBL_OFF_INT_MASK: imask_nxt = pwdata[IW-1:0];
				default: ;
			endcase
		end
		// events are applied after the clear so a same-cycle event is kept
		istat_nxt[SLOTS-1:0] = istat_nxt[SLOTS-1:0] | (pres_nxt ^ pres_r);
		istat_nxt[`DBL_INT_DONE_BIT] = istat_nxt[`DBL_INT_DONE_BIT] | done_evt;
		irq_nxt = |(istat_nxt & imask_nxt);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r <= `DBL_CTRL_RST;
			fault_r <= '0;
			rebuild_r <= '0;
			ident_r <= '0;
			spindn_r <= '0;
			istat_r <= '0;
			imask_r <= '0;
			prdata_r <= '0;
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			irq_r <= 1'b0;
			pres_r <= '0;
			cnt_rb_r <= '0;
			cnt_id_r <= '0;
			cnt_act_r <= '0;
			blink_rb_r <= 1'b0;
			blink_id_r <= 1'b0;
			blink_act_r <= 1'b0;
			pst_r <= dbl_pkg::DBL_PWR_OFF;
			slot_r <= '0;
			spin_cnt_r <= '0;
			pwr_r <= '0;
			amber_r <= '0;
			green_r <= '0;
		end else if (ce) begin
			ctrl_r <= ctrl_nxt;
			fault_r <= fault_nxt;
			rebuild_r <= rebuild_nxt;
			ident_r <= ident_nxt;
			spindn_r <= spindn_nxt;
			istat_r <= istat_nxt;
			imask_r <= imask_nxt;
			prdata_r <= prdata_nxt;
			pready_r <= pready_nxt;
			pslverr_r <= pslverr_nxt;
			irq_r <= irq_nxt;
			pres_r <= pres_nxt;
			cnt_rb_r <= cnt_rb_nxt;
			cnt_id_r <= cnt_id_nxt;
			cnt_act_r <= cnt_act_nxt;
			blink_rb_r <= blink_rb_nxt;
			blink_id_r <= blink_id_nxt;
			blink_act_r <= blink_act_nxt;
			pst_r <= pst_nxt;
			slot_r <= slot_nxt;
			spin_cnt_r <= spin_cnt_nxt;
			pwr_r <= pwr_nxt;
			amber_r <= amber_nxt;
			green_r <= green_nxt;
		end
	end

	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign irq = irq_r;
	assign led_amber = amber_r;
	assign led_green = green_r;
	assign drv_present = pres_r;
	assign drv_pwr_en = pwr_r;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_spin_slot0;
		pst_r == dbl_pkg::DBL_PWR_SPIN && slot_r == 3'h0 && ce;
	endsequence

	amber_dark_a: assert property (ce && !(fault_r[0] || rebuild_r[0] || ident_r[0]) |=> !led_amber[0])
		else $error("amber led lit with no request");
	fault_solid_a: assert property (ce && fault_r[1] && rebuild_r[1] |=> led_amber[1])
		else $error("fault did not win over blinking");
	rebuild_blink_a: assert property (ce && !fault_r[2] && rebuild_r[2] |=> led_amber[2] == $past(blink_rb_r))
		else $error("rebuild blink wrong");
	blink_half_a: assert property (ce && $changed(blink_id_r) |-> $past(cnt_id_r) == HALF_ID - 32'h1)
		else $error("identify blink toggled off its half period");
	sas_idle_a: assert property (ce && ctrl_r[0] && pwr_r[2] && !spindn_r[2] && !busy_s2_r[2]
		&& pst_r == dbl_pkg::DBL_PWR_ON |=> led_green[2])
		else $error("sas idle green not lit");
	sas_busy_a: assert property (ce && ctrl_r[0] && pst_r == dbl_pkg::DBL_PWR_ON && pwr_r[3] && !spindn_r[3]
		&& busy_s2_r[3] |=> led_green[3] == !$past(blink_act_r))
		else $error("sas busy green not blinking off");
	sata_busy_a: assert property (ce && !ctrl_r[0] && busy_s2_r[3] && !spindn_r[3] && pst_r == dbl_pkg::DBL_PWR_ON
		|=> led_green[3] == $past(blink_act_r))
		else $error("sata busy green not blinking on");
	spun_down_a: assert property (ce && spindn_r[4] |=> !led_green[4])
		else $error("spun down green lit");
	spinup_led_a: assert property (s_spin_slot0 |=> led_green[0] == ($past(ctrl_r[0]) && $past(blink_act_r)))
		else $error("spin-up green wrong");
	pwr_order_a: assert property (s_spin_slot0 |-> drv_pwr_en[0] && drv_pwr_en[SLOTS-1:1] == '0)
		else $error("drive powered out of order");
	apb_ready_a: assert property (ce && psel && !penable |=> pready ##1 (!pready || !ce))
		else $error("apb ready not one access cycle");
	pres_event_a: assert property (ce && pres_nxt[2] != pres_r[2] |=> istat_r[2])
		else $error("presence change not latched");
endmodule

`default_nettype wire

/* File: tb/dbl_drive_model.sv */
// behavioural drive bay: presence pins and busy lines of eight drives
// assumes the bench picks the fitted slots and the drives that get commands
`timescale 1ns/1ps
`default_nettype none
module dbl_drive_model (
	input wire logic pclk,
	input wire logic [7:0] fitted,
	input wire logic [7:0] cmd,
	input wire logic [7:0] pwr_en,
	output logic [7:0] detect_n,
	output logic [7:0] busy
);
	// an empty slot leaves its detect pin pulled high
	assign detect_n = ~fitted;
	// a drive without power cannot work on a command, whatever the host asks
	always_ff @(posedge pclk) begin
		busy <= cmd & fitted & pwr_en;
	end
endmodule
`default_nettype wire

/* File: tb/dbl_ctrl_tb_top.sv */
// self-checking bench of the drive bay led controller
// assumes short blink and spin-up parameters and the drive bay model on the pins
`timescale 1ns/1ps
`include "dbl_defs.svh"
`default_nettype none
module dbl_ctrl_tb_top;
	localparam int H_RB = 8;
	localparam int H_ID = 4;
	localparam int H_ACT = 2;
	localparam int SPIN = 20;
	logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, irq, er;
	logic [7:0] paddr, fitted, cmd, det_n, busy, led_amber, led_green, drv_present, drv_pwr_en;
	logic [31:0] pwdata, prdata, rd;
	int err_total, check_count;
	dbl_ctrl #(.HALF_RB(32'(H_RB)), .HALF_ID(32'(H_ID)), .HALF_ACT(32'(H_ACT)), .SPINUP_CYC(32'(SPIN))) dut (
		.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
		.drv_detect_n(det_n), .drv_busy(busy), .led_amber(led_amber), .led_green(led_green),
		.drv_present(drv_present), .drv_pwr_en(drv_pwr_en));
	dbl_drive_model bay (.pclk(pclk), .fitted(fitted), .cmd(cmd), .pwr_en(drv_pwr_en),
		.detect_n(det_n), .busy(busy));
	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic complete_run();
		$display("mismatches %0d, comparisons %0d", err_total, check_count);
		if (err_total == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// the master never assumes a latency; a wait ends on pready or at the retry bound
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		chk(32'(n < 50), 1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
		repeat (3) @(posedge pclk);
	endtask
	function automatic logic cur(input logic am, input int s);
		return am ? led_amber[s] : led_green[s];
	endfunction
	task automatic steady(input logic am, input int s, input logic v);
		int n;
		n = 0;
		repeat (10) begin
			@(negedge pclk);
			if (cur(am, s) !== v) n++;
		end
		chk(32'(n), 0);
	endtask
	// phase is unknown, so only whole intervals between two toggles are judged
	task automatic blink(input logic am, input int s, input int h);
		int n, t;
		logic v;
		n = 0;
		t = 0;
		v = cur(am, s);
		repeat (4 * h + 1) begin
			@(negedge pclk);
			n++;
			if (cur(am, s) !== v) begin
				if (t > 0) chk(32'(n), 32'(h));
				t++;
				n = 0;
				v = cur(am, s);
			end
		end
		chk(32'(t >= 3), 1);
	endtask
	task automatic t_reset();
		chk(32'({led_amber, led_green, drv_pwr_en}), 0);
		apb(1'b0, `DBL_OFF_CTRL, 0);
		chk(rd, 0);
		// presence lands on the same edge that completes the read, so look once it has settled
		@(negedge pclk);
		chk(32'(drv_present), 32'hFF);
	endtask
	task automatic t_amber();
		wr(`DBL_OFF_FAULT, 32'h03);
		apb(1'b0, `DBL_OFF_FAULT, 0);
		chk(rd, 32'h3);
		wr(`DBL_OFF_REBUILD, 32'h06);
		wr(`DBL_OFF_IDENT, 32'h0E);
		steady(1'b1, 0, 1'b1);
		steady(1'b1, 1, 1'b1);
		blink(1'b1, 2, H_RB);
		blink(1'b1, 3, H_ID);
		steady(1'b1, 4, 1'b0);
		wr(`DBL_OFF_FAULT, 0);
		steady(1'b1, 0, 1'b0);
	endtask
	task automatic t_spin_sas();
		int n;
		n = 0;
		wr(`DBL_OFF_CTRL, 32'h3);
		chk(32'(drv_pwr_en), 32'h01);
		blink(1'b0, 0, H_ACT);
		while (drv_pwr_en !== 8'hFF && n < 400) begin
			@(posedge pclk);
			n++;
		end
		chk(32'(n >= 6 * SPIN && n <= 7 * SPIN), 1);
		repeat (SPIN + 3) @(posedge pclk);
		apb(1'b0, `DBL_OFF_STATE, 0);
		chk(rd, 32'h0003FFFF);
		chk(32'(irq), 0);
		wr(`DBL_OFF_INT_MASK, 32'h100);
		chk(32'(irq), 1);
		wr(`DBL_OFF_INT_STAT, 32'h1FF);
		chk(32'(irq), 0);
	endtask
	task automatic t_green();
		@(posedge pclk);
		cmd <= 8'h39;
		wr(`DBL_OFF_SPINDN, 32'h10);
		steady(1'b0, 6, 1'b1);
		steady(1'b0, 4, 1'b0);
		blink(1'b0, 5, H_ACT);
		wr(`DBL_OFF_CTRL, 32'h2);
		steady(1'b0, 6, 1'b0);
		blink(1'b0, 5, H_ACT);
		steady(1'b0, 4, 1'b0);
		wr(`DBL_OFF_CTRL, 0);
		chk(32'(drv_pwr_en), 0);
		wr(`DBL_OFF_CTRL, 32'h2);
		steady(1'b0, 0, 1'b0);
		chk(32'(drv_pwr_en), 32'h01);
	endtask
	task automatic t_unmapped();
		apb(1'b1, 8'h20, 32'hFFFFFFFF);
		chk(32'(er), 1);
		apb(1'b0, 8'h20, 0);
		chk(32'(er), 1);
		chk(rd, 0);
	endtask
	// pull one drive, then freeze the block and check the blinking amber leds hold still
	task automatic t_hotplug();
		logic [7:0] snap;
		int n;
		n = 0;
		@(posedge pclk);
		fitted <= 8'hFB;
		repeat (4) @(posedge pclk);
		@(negedge pclk);
		chk(32'(drv_present), 32'hFB);
		apb(1'b0, `DBL_OFF_INT_STAT, 0);
		chk(rd, 32'h4);
		@(posedge pclk);
		ce <= 1'b0;
		@(negedge pclk);
		snap = led_amber;
		repeat (20) begin
			@(negedge pclk);
			if (led_amber !== snap) n++;
		end
		chk(32'(n), 0);
		@(posedge pclk);
		ce <= 1'b1;
		blink(1'b1, 3, H_ID);
	endtask
	initial begin
		err_total = 0;
		check_count = 0;
		presetn = 1'b0;
		ce = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		fitted = 8'hFF;
		cmd = 8'h00;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(negedge pclk);
		t_reset();
		t_amber();
		t_spin_sas();
		t_green();
		t_unmapped();
		t_hotplug();
		complete_run();
	end
	// the whole run needs well under 1000 cycles
	initial begin
		#40000;
		err_total++;
		complete_run();
	end
endmodule
`default_nettype wire
